/* File: sdc_defines.svh */
// Named constants for the sigma-delta calibration sequencer and its host.
// Assumes every user of these macros includes this file by its bare name.
`ifndef SDC_DEFINES_SVH
`define SDC_DEFINES_SVH

`define SDC_WORD_BITS      20
`define SDC_UNI_SHIFT      20
`define SDC_BIP_SHIFT      19
`define SDC_FMAX_HZ        4096000
`define SDC_WORD_RATE_HZ   4000
`define SDC_WORD_CYCLES    (`SDC_FMAX_HZ / `SDC_WORD_RATE_HZ)
`define SDC_SELF_CYCLES    3145655
`define SDC_OFFSET_CYCLES  1052599
`define SDC_GAIN_CYCLES    1068813
`define SDC_OFFREF_CYCLES  2117389
`define SDC_CAL_HIGH_MIN   4
`define SDC_CODE_ZERO      20'h00000
`define SDC_CODE_FULL      20'hFFFFF
`define SDC_CODE_MID       20'h80000

`define SDC_ADDR_CTRL      4'h0
`define SDC_ADDR_CMD       4'h4
`define SDC_ADDR_STATUS    4'h8
`define SDC_ADDR_RESULT    4'hC
`define SDC_CTRL_SEL_A     0
`define SDC_CTRL_SEL_B     1
`define SDC_CTRL_POL       2
`define SDC_CMD_START      0
`define SDC_ST_BUSY        0
`define SDC_ST_VALID       1
`define SDC_ST_OFFSET_DONE 2
`define SDC_ST_DONE        3
`define SDC_ST_REFUSED     4

`endif

/* File: sdc_device.sv */
// Converter end: continuous conversion, calibration sequencing, slope and coding.
// Assumes AIN, REF_LEVEL and AGND_LEVEL are modulator results synchronous to MCLK.
// Function
// - Convert continuously once a calibration step has finished, no start request needed
// - Refresh 20-bit word at 4 kHz
// - Result readable any time, no alignment
// - Capture zero-scale and full-scale points
// - Self-cal: ground zero, reference full scale
// - Unipolar slope is span over 2^20
// - Bipolar slope is span over 2^19
// - Stored slope applied to every conversion
// - System cal samples both points at input
// - Host runs offset step before gain step
// - Host holds input steady during step
// - Word-valid low marks system step done
// - Host applies full scale, then gain step
// - Offset-only recalibration allowed after sequence
// - Offset-only: input zero, reference full scale
// - Polarity low unipolar, high bipolar span
// - Straight binary unipolar, offset binary bipolar
// - All rates scale with master clock
// - Host holds request high four cycles
// - Selects latched on request rising edge
// - Word-valid high for whole step length
// - System step loads zeros or ones
`timescale 1ns/100ps
`include "sdc_defines.svh"

module sdc_device #(
    parameter int MW            = 24,
    parameter int WORD_CYCLES   = `SDC_WORD_CYCLES,
    parameter int SELF_CYCLES   = `SDC_SELF_CYCLES,
    parameter int OFFSET_CYCLES = `SDC_OFFSET_CYCLES,
    parameter int GAIN_CYCLES   = `SDC_GAIN_CYCLES,
    parameter int OFFREF_CYCLES = `SDC_OFFREF_CYCLES
) (
    input  wire logic                 MCLK,       // master clock
    input  wire logic                 RST,        // synchronous reset, high
    sdc_if.dev                        LINK,       // pins toward the host
    input  wire logic signed [MW-1:0] AIN,        // modulator result at input
    input  wire logic signed [MW-1:0] REF_LEVEL,  // modulator result at reference
    input  wire logic signed [MW-1:0] AGND_LEVEL  // modulator result at analog ground
);
    localparam int WB = `SDC_WORD_BITS;
    localparam int DW = MW + 1;
    localparam int NW = DW + `SDC_UNI_SHIFT;
    localparam int CW = $clog2(NW + 1);

    sdc_pkg::sdc_dev_state_e state;
    sdc_pkg::sdc_mode_e      mode;
    logic                    cal_q;
    logic [2:0]              high_cnt;
    logic [31:0]             cal_cnt;
    logic [15:0]             word_cnt;
    logic signed [MW-1:0]    zero_lvl;
    logic signed [MW-1:0]    full_lvl;
    logic [DW-1:0]           span_raw;
    logic [DW-1:0]           span;
    logic [DW-1:0]           diff;
    logic [DW-1:0]           mag;
    logic [NW-1:0]           num_c;
    logic [NW-1:0]           div_num;
    logic [DW-1:0]           div_rem;
    logic [NW-1:0]           div_quo;
    logic [CW-1:0]           div_cnt;
    logic                    div_busy;
    logic                    div_neg;
    logic                    div_pol;
    logic [DW:0]             rem_shift;
    logic                    ge;
    logic                    res_ready;
    logic                    calibrated;
    logic                    self_kick;
    logic [WB-1:0]           word;
    logic                    wvn;
    logic                    cal_rise;
    logic                    cal_fall;
    logic                    long_enough;
    logic                    step_start;
    logic                    cal_end;
    logic                    tick;
    logic                    conv_start;

    function automatic logic [31:0] step_len(input sdc_pkg::sdc_mode_e m);
        unique case (m)
            sdc_pkg::MODE_SELF:       step_len = 32'(SELF_CYCLES);
            sdc_pkg::MODE_SYS_OFFSET: step_len = 32'(OFFSET_CYCLES);
            sdc_pkg::MODE_SYS_GAIN:   step_len = 32'(GAIN_CYCLES);
            sdc_pkg::MODE_OFFSET_REF: step_len = 32'(OFFREF_CYCLES);
        endcase
    endfunction

    // Quotient is the code distance from the zero point; clamp to the word range
    function automatic logic [WB-1:0] form_code(input logic [NW-1:0] q,
                                                input logic          neg,
                                                input logic          pol);
        logic signed [NW+1:0] off;
        logic signed [NW+1:0] qs;
        logic signed [NW+1:0] v;
        off = pol ? (NW+2)'(`SDC_CODE_MID) : (NW+2)'(`SDC_CODE_ZERO);
        qs  = $signed({2'h0, q});
        v   = neg ? off - qs : off + qs;
        if (v < 0)
            form_code = `SDC_CODE_ZERO;
        else if (v > $signed((NW+2)'(`SDC_CODE_FULL)))
            form_code = `SDC_CODE_FULL;
        else
            form_code = v[WB-1:0];
    endfunction

    assign cal_rise    = LINK.cal & ~cal_q;
    assign cal_fall    = ~LINK.cal & cal_q;
    assign long_enough = high_cnt >= 3'(`SDC_CAL_HIGH_MIN);
    assign step_start  = state == sdc_pkg::ST_ARMED && cal_fall && long_enough;
    assign cal_end     = state == sdc_pkg::ST_CAL && cal_cnt == step_len(mode) - 32'h1;
    assign tick        = word_cnt == 16'(WORD_CYCLES - 1);

    always_ff @(posedge MCLK) begin
        if (RST)
            cal_q <= 1'b0;
        else
            cal_q <= LINK.cal;
    end

    always_ff @(posedge MCLK) begin
        if (RST)
            high_cnt <= 3'h0;
        else if (cal_rise)
            high_cnt <= 3'h1;
        else if (LINK.cal && high_cnt != 3'h7)
            high_cnt <= high_cnt + 3'h1;
    end

    // A step in progress must finish; requests during it are ignored
    always_ff @(posedge MCLK) begin
        if (RST)
            state <= sdc_pkg::ST_RUN;
        else begin
            unique case (state)
                sdc_pkg::ST_RUN:   if (cal_rise) state <= sdc_pkg::ST_ARMED;
                sdc_pkg::ST_ARMED: if (cal_fall) state <= long_enough ? sdc_pkg::ST_CAL
                                                                      : sdc_pkg::ST_RUN;
                sdc_pkg::ST_CAL:   if (cal_end) state <= sdc_pkg::ST_RUN;
            endcase
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST)
            mode <= sdc_pkg::MODE_SELF;
        else if (state == sdc_pkg::ST_RUN && cal_rise)
            mode <= sdc_pkg::sdc_decode(LINK.cal_select_a, LINK.cal_select_b);
    end

    always_ff @(posedge MCLK) begin
        if (RST || step_start)
            cal_cnt <= 32'h0;
        else if (state == sdc_pkg::ST_CAL)
            cal_cnt <= cal_cnt + 32'h1;
    end

    // Input is assumed steady through the step, so the points are taken at its end
    always_ff @(posedge MCLK) begin
        if (RST) begin
            zero_lvl <= '0;
            full_lvl <= '0;
        end else if (cal_end) begin
            unique case (mode)
                sdc_pkg::MODE_SELF: begin
                    zero_lvl <= AGND_LEVEL;
                    full_lvl <= REF_LEVEL;
                end
                sdc_pkg::MODE_SYS_OFFSET: zero_lvl <= AIN;
                sdc_pkg::MODE_SYS_GAIN:   full_lvl <= AIN;
                sdc_pkg::MODE_OFFSET_REF: begin
                    zero_lvl <= AIN;
                    full_lvl <= REF_LEVEL;
                end
            endcase
        end
    end

    // Stored slope is the span; the power-of-two divisor becomes a numerator shift
    assign span_raw = {full_lvl[MW-1], full_lvl} - {zero_lvl[MW-1], zero_lvl};
    assign span     = (span_raw[DW-1] || span_raw == '0) ? DW'(1) : span_raw;
    assign diff     = {AIN[MW-1], AIN} - {zero_lvl[MW-1], zero_lvl};
    assign mag      = diff[DW-1] ? DW'(-diff) : diff;
    assign num_c    = LINK.polarity_select ? {1'b0, mag, `SDC_BIP_SHIFT'(0)}
                                           : {mag, `SDC_UNI_SHIFT'(0)};

    always_ff @(posedge MCLK) begin
        if (RST || tick)
            word_cnt <= 16'h0;
        else
            word_cnt <= word_cnt + 16'h1;
    end

    always_ff @(posedge MCLK) begin
        if (RST)
            self_kick <= 1'b0;
        else
            self_kick <= cal_end && mode == sdc_pkg::MODE_SELF;
    end

    assign conv_start = state != sdc_pkg::ST_CAL && calibrated && !div_busy
                        && (tick || self_kick);
    assign rem_shift  = {div_rem, div_num[NW-1]};
    assign ge         = rem_shift >= {1'b0, span};

    // Serial long division, one quotient bit per cycle, well inside a word period
    always_ff @(posedge MCLK) begin
        if (RST) begin
            div_busy <= 1'b0;
            div_cnt  <= '0;
            div_num  <= '0;
            div_rem  <= '0;
            div_quo  <= '0;
            div_neg  <= 1'b0;
            div_pol  <= 1'b0;
        end else if (conv_start) begin
            div_busy <= 1'b1;
            div_cnt  <= CW'(NW);
            div_num  <= num_c;
            div_rem  <= '0;
            div_quo  <= '0;
            div_neg  <= diff[DW-1];
            div_pol  <= LINK.polarity_select;
        end else if (div_busy) begin
            div_num  <= div_num << 1;
            div_rem  <= ge ? DW'(rem_shift - {1'b0, span}) : rem_shift[DW-1:0];
            div_quo  <= {div_quo[NW-2:0], ge};
            div_cnt  <= div_cnt - CW'(1);
            if (div_cnt == CW'(1))
                div_busy <= 1'b0;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST)
            res_ready <= 1'b0;
        else
            res_ready <= div_busy && div_cnt == CW'(1);
    end

    // Whole word changes in one edge, so a read never sees a mix of two results
    always_ff @(posedge MCLK) begin
        if (RST) begin
            word       <= `SDC_CODE_ZERO;
            wvn        <= 1'b1;
            calibrated <= 1'b0;
        end else if (step_start) begin
            wvn <= 1'b1;
        end else if (cal_end) begin
            calibrated <= 1'b1;
            if (mode != sdc_pkg::MODE_SELF) begin
                word <= mode == sdc_pkg::MODE_SYS_GAIN ? `SDC_CODE_FULL
                                                       : `SDC_CODE_ZERO;
                wvn  <= 1'b0;
            end
        end else if (res_ready && state != sdc_pkg::ST_CAL) begin
            word <= form_code(div_quo, div_neg, div_pol);
            wvn  <= 1'b0;
        end
    end

    assign LINK.word         = word;
    assign LINK.word_valid_n = wvn;
endmodule

/* File: sdc_host.sv */
// Host end: register port for software, drives calibration pins, reads result.
// Assumes the device end shares MCLK; software uses the plain strobe port.
`timescale 1ns/100ps
`include "sdc_defines.svh"

module sdc_host #(
    parameter int HIGH_CYCLES = `SDC_CAL_HIGH_MIN
) (
    input  wire logic        MCLK,  // master clock
    input  wire logic        RST,   // synchronous reset, high
    sdc_if.host              LINK,  // pins toward the converter
    input  wire logic [3:0]  ADDR,  // register byte address
    input  wire logic [31:0] WDATA, // write data
    input  wire logic        WR,    // write strobe
    input  wire logic        RD,    // read strobe
    output logic      [31:0] RDATA  // read data, cycle after RD
);
    sdc_pkg::sdc_host_state_e hstate;
    sdc_pkg::sdc_mode_e       step_mode;
    logic                     sel_a;
    logic                     sel_b;
    logic                     pol;
    logic                     cal;
    logic [7:0]               pulse_cnt;
    logic                     offset_done;
    logic                     done;
    logic                     refused;
    logic                     start_req;
    logic                     gain_bad;
    logic                     accept;
    logic                     finish;
    logic                     ctrl_wr;

    assign ctrl_wr   = WR && ADDR == `SDC_ADDR_CTRL && hstate == sdc_pkg::H_IDLE;
    assign start_req = WR && ADDR == `SDC_ADDR_CMD && WDATA[`SDC_CMD_START];
    // Gain step without a finished offset step is refused
    assign gain_bad  = sdc_pkg::sdc_decode(sel_a, sel_b) == sdc_pkg::MODE_SYS_GAIN
                       && !offset_done;
    assign accept    = start_req && hstate == sdc_pkg::H_IDLE && !gain_bad;
    assign finish    = hstate == sdc_pkg::H_WAIT_LO && !LINK.word_valid_n;

    // Selects and polarity only change while idle, so they are stable around the pulse
    always_ff @(posedge MCLK) begin
        if (RST) begin
            sel_a <= 1'b0;
            sel_b <= 1'b0;
            pol   <= 1'b0;
        end else if (ctrl_wr) begin
            sel_a <= WDATA[`SDC_CTRL_SEL_A];
            sel_b <= WDATA[`SDC_CTRL_SEL_B];
            pol   <= WDATA[`SDC_CTRL_POL];
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            hstate    <= sdc_pkg::H_IDLE;
            cal       <= 1'b0;
            pulse_cnt <= 8'h0;
            step_mode <= sdc_pkg::MODE_SELF;
        end else begin
            unique case (hstate)
                sdc_pkg::H_IDLE: if (accept) begin
                    hstate    <= sdc_pkg::H_PULSE;
                    cal       <= 1'b1;
                    pulse_cnt <= 8'h0;
                    step_mode <= sdc_pkg::sdc_decode(sel_a, sel_b);
                end
                sdc_pkg::H_PULSE: begin
                    pulse_cnt <= pulse_cnt + 8'h1;
                    if (pulse_cnt == 8'(HIGH_CYCLES - 1)) begin
                        cal    <= 1'b0;
                        hstate <= sdc_pkg::H_WAIT_HI;
                    end
                end
                sdc_pkg::H_WAIT_HI: if (LINK.word_valid_n) hstate <= sdc_pkg::H_WAIT_LO;
                sdc_pkg::H_WAIT_LO: if (finish) hstate <= sdc_pkg::H_IDLE;
            endcase
        end
    end

    // A polarity change voids the stored calibration sequence
    always_ff @(posedge MCLK) begin
        if (RST || (ctrl_wr && WDATA[`SDC_CTRL_POL] != pol))
            offset_done <= 1'b0;
        else if (finish && step_mode == sdc_pkg::MODE_SYS_OFFSET)
            offset_done <= 1'b1;
    end

    always_ff @(posedge MCLK) begin
        if (RST)
            done <= 1'b0;
        else if (finish)
            done <= 1'b1;
        else if (accept)
            done <= 1'b0;
    end

    // Set wins over the read-to-clear in the same cycle
    always_ff @(posedge MCLK) begin
        if (RST)
            refused <= 1'b0;
        else if (start_req && !accept)
            refused <= 1'b1;
        else if (RD && ADDR == `SDC_ADDR_STATUS)
            refused <= 1'b0;
    end

    always_ff @(posedge MCLK) begin
        if (RST)
            RDATA <= 32'h0;
        else if (RD) begin
            unique case (ADDR)
                `SDC_ADDR_CTRL:   RDATA <= 32'({pol, sel_b, sel_a});
                `SDC_ADDR_STATUS: RDATA <= 32'({refused, done, offset_done,
                                                ~LINK.word_valid_n,
                                                hstate != sdc_pkg::H_IDLE});
                `SDC_ADDR_RESULT: RDATA <= 32'(LINK.word);
                default:          RDATA <= 32'h0;
            endcase
        end else
            RDATA <= 32'h0;
    end

    assign LINK.cal             = cal;
    assign LINK.cal_select_a    = sel_a;
    assign LINK.cal_select_b    = sel_b;
    assign LINK.polarity_select = pol;
endmodule

/* File: sdc_if.sv */
// Pin bundle between the converter's calibration logic and its host.
// Assumes both ends share MCLK; the testbench instantiates and joins them.
`timescale 1ns/100ps
`include "sdc_defines.svh"

interface sdc_if;
    logic                      cal;
    logic                      cal_select_a;
    logic                      cal_select_b;
    logic                      polarity_select;
    logic                      word_valid_n;
    logic [`SDC_WORD_BITS-1:0] word;

    modport dev (
        input  cal, cal_select_a, cal_select_b, polarity_select,
        output word_valid_n, word
    );

    modport host (
        output cal, cal_select_a, cal_select_b, polarity_select,
        input  word_valid_n, word
    );
endinterface

/* File: sdc_pkg.sv */
// Types shared by both ends of the calibration sequencer link.
// Assumes sdc_defines.svh is on the include path.
`include "sdc_defines.svh"

package sdc_pkg;

    typedef enum logic [1:0] {
        MODE_SELF,
        MODE_SYS_OFFSET,
        MODE_SYS_GAIN,
        MODE_OFFSET_REF
    } sdc_mode_e;

    typedef enum {ST_RUN, ST_ARMED, ST_CAL} sdc_dev_state_e;

    typedef enum {H_IDLE, H_PULSE, H_WAIT_HI, H_WAIT_LO} sdc_host_state_e;

    function automatic sdc_mode_e sdc_decode(input logic sel_a, input logic sel_b);
        unique case ({sel_a, sel_b})
            2'h0: sdc_decode = MODE_SELF;
            2'h3: sdc_decode = MODE_SYS_OFFSET;
            2'h1: sdc_decode = MODE_SYS_GAIN;
            2'h2: sdc_decode = MODE_OFFSET_REF;
        endcase
    endfunction

endpackage

/* File: sdc_properties.sv */
// Concurrent checks on the link between the converter end and the host end.
// Assumes one clock and a synchronous high reset shared by both ends.
`timescale 1ns/100ps
`include "sdc_defines.svh"

module sdc_properties #(
    parameter int SELF_CYCLES   = `SDC_SELF_CYCLES,
    parameter int OFFSET_CYCLES = `SDC_OFFSET_CYCLES,
    parameter int GAIN_CYCLES   = `SDC_GAIN_CYCLES,
    parameter int OFFREF_CYCLES = `SDC_OFFREF_CYCLES
) (
    input wire logic                      MCLK,            // master clock
    input wire logic                      RST,             // synchronous reset
    input wire logic                      cal,             // calibrate request
    input wire logic                      cal_select_a,    // step select a
    input wire logic                      cal_select_b,    // step select b
    input wire logic                      polarity_select, // range select
    input wire logic                      word_valid_n,    // word valid, low
    input wire logic [`SDC_WORD_BITS-1:0] word             // result word
);
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (RST);

    logic [1:0] mode;
    logic       cal_q;
    logic       pol_q;
    logic       wv_q;
    logic       offset_ok;
    int         hi_cnt;

    always_ff @(posedge MCLK) begin
        cal_q <= cal;
        pol_q <= polarity_select;
        wv_q  <= word_valid_n;
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            mode <= 2'h0;
        end else if (cal && !cal_q) begin
            mode <= {cal_select_a, cal_select_b};
        end
    end

    // Cleared by the request, so idle time after reset never counts as step time
    always_ff @(posedge MCLK) begin
        if (RST || cal || !word_valid_n) begin
            hi_cnt <= '0;
        end else begin
            hi_cnt <= hi_cnt + 1;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST || polarity_select != pol_q) begin
            offset_ok <= 1'b0;
        end else if (wv_q && !word_valid_n && mode == 2'h3) begin
            offset_ok <= 1'b1;
        end
    end

    AST_CAL_MIN:
        assert property ($rose(cal) |=> cal [*3]) else $error("calibrate request too short");
    AST_STEP_HIGH:
        assert property (cal [*4] ##1 !cal |-> ##2 word_valid_n [*8])
            else $error("word valid not held high in step");
    AST_SELF_LEN:
        assert property ($fell(word_valid_n) && mode == 2'h0
            |-> hi_cnt inside {[SELF_CYCLES-3:SELF_CYCLES+70]}) else $error("self step length");
    AST_OFFSET_LEN:
        assert property ($fell(word_valid_n) && mode == 2'h3
            |-> hi_cnt inside {[OFFSET_CYCLES-3:OFFSET_CYCLES+3]}) else $error("offset step length");
    AST_GAIN_LEN:
        assert property ($fell(word_valid_n) && mode == 2'h1
            |-> hi_cnt inside {[GAIN_CYCLES-3:GAIN_CYCLES+3]}) else $error("gain step length");
    AST_OFFREF_LEN:
        assert property ($fell(word_valid_n) && mode == 2'h2
            |-> hi_cnt inside {[OFFREF_CYCLES-3:OFFREF_CYCLES+3]}) else $error("offset-only length");
    AST_SYS_ZERO:
        assert property ($fell(word_valid_n) && mode[1] |-> word == `SDC_CODE_ZERO)
            else $error("zero-scale step word not all zeros");
    AST_SYS_FULL:
        assert property ($fell(word_valid_n) && mode == 2'h1 |-> word == `SDC_CODE_FULL)
            else $error("full-scale step word not all ones");
    AST_GAIN_ORDER:
        assert property ($rose(cal) && !cal_select_a && cal_select_b |-> offset_ok)
            else $error("gain step without offset step");
    AST_SEL_HOLD:
        assert property (cal && $past(cal)
            |-> $stable({cal_select_a, cal_select_b, polarity_select}))
            else $error("selects moved during request");
    AST_WORD_HOLD:
        assert property (word_valid_n && $past(word_valid_n) |-> $stable(word))
            else $error("word moved while not valid");

    COV_SELF: cover property ($fell(word_valid_n) && mode == 2'h0);
    COV_GAIN: cover property ($fell(word_valid_n) && mode == 2'h1);
    COV_OFFREF: cover property ($fell(word_valid_n) && mode == 2'h2);
endmodule

/* File: tb_sigma_delta_cal_sequencer.sv */
// Testbench: host and converter ends joined by the link, driven through the register port.
// Assumes shortened step and word lengths; expected codes are computed here.
`timescale 1ns/100ps
`include "sdc_defines.svh"
`define CHK(nm, ex, gt) begin check_count++; if ((gt) !== (ex)) begin num_errors++; \
    $display("Error %s expected %h seen %h", nm, ex, gt); end end

module tb_sigma_delta_cal_sequencer;
    localparam int WCYC     = 128;
    localparam int MW       = 24;
    localparam int SELF_C   = 200;
    localparam int OFFSET_C = 100;
    localparam int GAIN_C   = 120;
    localparam int OFFREF_C = 150;
    logic               MCLK;
    logic               RST;
    logic [3:0]         ADDR;
    logic [31:0]        WDATA;
    logic               WR;
    logic               RD;
    logic [31:0]        RDATA;
    logic signed [23:0] AIN;
    logic signed [23:0] REF_LEVEL;
    logic signed [23:0] AGND_LEVEL;
    int                 num_errors;
    int                 check_count;
    int                 cycles;
    int                 seed;
    logic [31:0]        rdv;
    longint             zp;
    longint             fp;

    sdc_if link ();
    sdc_device #(.MW(MW), .WORD_CYCLES(WCYC), .SELF_CYCLES(SELF_C), .OFFSET_CYCLES(OFFSET_C),
        .GAIN_CYCLES(GAIN_C), .OFFREF_CYCLES(OFFREF_C)) sdc_device_i (.MCLK(MCLK), .RST(RST),
        .LINK(link), .AIN(AIN), .REF_LEVEL(REF_LEVEL), .AGND_LEVEL(AGND_LEVEL));
    sdc_host sdc_host_i (.MCLK(MCLK), .RST(RST), .LINK(link), .ADDR(ADDR), .WDATA(WDATA),
        .WR(WR), .RD(RD), .RDATA(RDATA));
    sdc_properties #(.SELF_CYCLES(SELF_C), .OFFSET_CYCLES(OFFSET_C), .GAIN_CYCLES(GAIN_C),
        .OFFREF_CYCLES(OFFREF_C)) sdc_properties_i (.MCLK(MCLK), .RST(RST), .cal(link.cal),
        .cal_select_a(link.cal_select_a), .cal_select_b(link.cal_select_b),
        .polarity_select(link.polarity_select), .word_valid_n(link.word_valid_n),
        .word(link.word));

    initial begin
        MCLK = 1'b0;
        forever #5 MCLK = ~MCLK;
    end

    // Every step plus its conversions stays far below this ceiling
    always @(posedge MCLK) begin
        cycles++;
        if (cycles == 30000) begin
            num_errors++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("Checks %0d, errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge MCLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge MCLK);
        WR <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a);
        @(posedge MCLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge MCLK);
        RD <= 1'b0;
        #1 rdv = RDATA;
    endtask

    function automatic logic [19:0] exp_code(longint a, longint z, longint f, logic pol);
        longint s;
        longint q;
        s = (f > z) ? f - z : 64'sh1;
        q = pol ? 64'sh80000 + (a - z) * 64'sh80000 / s : (a - z) * 64'sh100000 / s;
        if (q[63]) q = 64'sh0;
        if (q > 64'shFFFFF) q = 64'shFFFFF;
        return q[19:0];
    endfunction

    function automatic longint rnd(longint lo, longint span);
        return lo + longint'($unsigned($random(seed)) % span);
    endfunction

    // ctrl: bit0 select a, bit1 select b, bit2 polarity
    task automatic run_step(input logic [2:0] ctrl);
        int n;
        wr(`SDC_ADDR_CTRL, {29'h0, ctrl});
        wr(`SDC_ADDR_CMD, 32'h1);
        n = 0;
        rdv = 32'h1;
        while (rdv[`SDC_ST_BUSY] !== 1'b0 && n < 2000) begin
            rd(`SDC_ADDR_STATUS);
            n++;
        end
        `CHK("step done", 1'b1, rdv[`SDC_ST_DONE])
        `CHK("word valid", 1'b1, rdv[`SDC_ST_VALID])
    endtask

    // Two word periods plus divider latency guarantee a conversion of the new input
    task automatic conv(input longint a, input logic pol);
        @(posedge MCLK);
        AIN <= a[23:0];
        repeat (2 * WCYC + 60) @(posedge MCLK);
        rd(`SDC_ADDR_RESULT);
        `CHK("result", {12'h0, exp_code(a, zp, fp, pol)}, rdv)
        rd(`SDC_ADDR_RESULT);
        `CHK("result again", {12'h0, exp_code(a, zp, fp, pol)}, rdv)
    endtask

    initial begin
        seed = 32'h539E2825;
        RST = 1'b1;
        WR = 1'b0;
        RD = 1'b0;
        ADDR = 4'h0;
        WDATA = 32'h0;
        AIN = 24'sh0;
        AGND_LEVEL = 24'(rnd(-64'sd2000, 64'sd4000));
        REF_LEVEL = AGND_LEVEL + 24'(rnd(64'sd200000, 64'sd100000));
        repeat (8) @(posedge MCLK);
        RST <= 1'b0;
        rd(`SDC_ADDR_RESULT);
        `CHK("result after reset", 32'h0, rdv)
        rd(`SDC_ADDR_STATUS);
        `CHK("valid after reset", 1'b0, rdv[`SDC_ST_VALID])
        rd(4'h1);
        `CHK("unmapped", 32'h0, rdv)
        zp = AGND_LEVEL;
        fp = REF_LEVEL;
        run_step(3'h0);
        repeat (3) conv(rnd(zp, fp - zp), 1'b0);
        conv(zp - 5, 1'b0);
        conv(fp + 5, 1'b0);
        run_step(3'h4);
        conv(zp, 1'b1);
        repeat (2) conv(rnd(zp, fp - zp), 1'b1);
        conv(fp + 5, 1'b1);
        wr(`SDC_ADDR_CTRL, 32'h2);
        wr(`SDC_ADDR_CMD, 32'h1);
        rd(`SDC_ADDR_STATUS);
        `CHK("gain refused", 1'b1, rdv[`SDC_ST_REFUSED])
        rd(`SDC_ADDR_STATUS);
        `CHK("refusal cleared", 1'b0, rdv[`SDC_ST_REFUSED])
        zp = rnd(-64'sd50000, 64'sd100000);
        fp = zp + rnd(64'sd250000, 64'sd100000);
        @(posedge MCLK);
        AIN <= zp[23:0];
        run_step(3'h3);
        rd(`SDC_ADDR_STATUS);
        `CHK("offset done", 1'b1, rdv[`SDC_ST_OFFSET_DONE])
        @(posedge MCLK);
        AIN <= fp[23:0];
        run_step(3'h2);
        repeat (3) conv(rnd(zp, fp - zp), 1'b0);
        zp = rnd(-64'sd50000, 64'sd100000);
        fp = REF_LEVEL;
        @(posedge MCLK);
        AIN <= zp[23:0];
        run_step(3'h1);
        repeat (2) conv(rnd(zp, fp - zp), 1'b0);
        print_verdict();
    end
endmodule
